// file: bsst_consts.svh
// Constants of the byte-synchronous serial transmitter: register offsets,
// command codes, reset values, CRC polynomials and queue depth.
// Assumes inclusion by bare name from the design file only.
`ifndef BSST_CONSTS_SVH
`define BSST_CONSTS_SVH

// ==========================================================================
// Register word indices (address bits 7:2) on the 32-bit bus
`define BSST_OFS_CMD      6'h00
`define BSST_OFS_MRESET   6'h01
`define BSST_OFS_MODE     6'h02
`define BSST_OFS_RXCTL    6'h03
`define BSST_OFS_TXCTL    6'h04
`define BSST_OFS_SYNCLO   6'h05
`define BSST_OFS_SYNCHI   6'h06
`define BSST_OFS_MISC     6'h07
`define BSST_OFS_EXTFIFO  6'h08
`define BSST_OFS_TXDATA   6'h09
`define BSST_OFS_STATUS   6'h0a

// ==========================================================================
// Reset values and command codes (command bits 7:6)
`define BSST_REG_RST      8'h00
`define BSST_CMD_TXCRC    2'h2
`define BSST_CMD_EOM      2'h3

// ==========================================================================
// CRC polynomials and transmit queue depth
`define BSST_POLY_CRC16   16'h8005
`define BSST_POLY_CCITT   16'h1021
`define BSST_FIFO_DEPTH   3'h4

`endif

// file: bsst_pkg.sv
// Types shared by the byte-synchronous serial transmitter.
// Assumes nothing of its surroundings.
package bsst_pkg;

  // ========================================================================
  // Classic Wishbone request as one carrier
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } bsst_wb_req_t;

  // ========================================================================
  // What the shift register currently holds
  typedef enum logic [1:0] {
    BSST_IDLE,
    BSST_SYNC,
    BSST_DATA,
    BSST_CRC
  } bsst_kind_t;

endpackage

// file: bsst_tx.sv
// Byte-synchronous serial transmitter with a Wishbone register file.
// Assumes a 1x transmit clock from the line partner and a classic
// Wishbone master on clk_i; the receiver lives elsewhere.
//
// How it works
// R1: Host resets via master reset control, then programs mode first.
// R2: Transmitter runs only with transmit control D3; receiver enable on D0.
// R3: Mode bits 5:4 zero with length bit set sends six low sync bits.
// R4: Mode bits 5:4 zero with length bit clear idles the 8-bit low sync.
// R5: Mode 5:4 equal 01 with length bit clear idles 16-bit sync pair.
// R6: Twelve-bit sync is receiver only; external sync sends six or eight.
// R7: Mode bits 3:2 zero select sync mode; bits 5:4 pick the variant.
// R8: Clock mode forced to 00 outside external sync; host programs 00.
// R9: Transmit control 6:5 pick 5 to 8 bits, right justified data.
// R10: In five-bit setting host pre-formats bytes for one to five bits.
// R11: Mode D0 appends parity; D1 set gives even, clear gives odd.
// R12: Transmit control D2 picks CRC-16 when set, CCITT when clear.
// R13: Misc D7 presets CRC to all ones when set, zeros when clear.
// R14: No automatic preset; host issues reset-CRC command while idling sync.
// R15: CRC accumulates only when enabled; sync characters never included.
// R16: CRC enable sampled as each character enters the shift register.
// R17: With extended D5 clear, buffer-empty flags only a fully empty queue.
// R18: Characters go back to back with no start or stop bits.
// R19: Underrun with latch clear sends CRC, then sets the latch.
// R20: Request-to-send pin drives inverse of transmit control D1.
// R21: Auto enable on: clear-to-send high stops, low enables transmitter.
// R22: Idle transmitter repeats sync, switching seamlessly to written data.
//
// The Wishbone register port and the address map are this design's own decisions.
`include "bsst_consts.svh"

module bsst_tx (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire bsst_pkg::bsst_wb_req_t wb_i,
  output      logic                  wb_ack_o,
  output      logic [31:0]           wb_dat_o,
  // Serial line and modem pins
  input  wire logic                  txc_i,
  input  wire logic                  cts_n_i,
  output      logic                  txd_o,
  output      logic                  rts_n_o,
  output      logic                  rx_en_o
);
  import bsst_pkg::*;

  // ========================================================================
  // Helper functions

  // Bit count of a pre-formatted five-bit-setting byte
  function automatic logic [3:0] five_len(input logic [7:0] d);
    if (d[7:4] == 4'hf) return 4'h1;
    if (d[7:5] == 3'h7) return 4'h2;
    if (d[7:6] == 2'h3) return 4'h3;
    if (d[7]) return 4'h4;
    return 4'h5;
  endfunction

  // Data character frame: {length, value}, sent LSB first
  function automatic logic [20:0] data_frame(input logic [7:0] d,
      input logic [1:0] bpc, input logic pen, input logic peven);
    logic [3:0] n;
    logic [8:0] m;
    logic [8:0] v;
    case (bpc)
      2'h0: n = five_len(d); // [R10]
      2'h1: n = 4'h7;
      2'h2: n = 4'h6;
      default: n = 4'h8;
    endcase
    m = (9'h001 << n) - 9'h001;
    v = {1'b0, d} & m;
    if (pen) begin
      v[n] = peven ? ^v : ~^v;
    end
    return {{1'b0, n} + {4'h0, pen}, 7'h00, v};
  endfunction

  // Sync frame for the selected variant: {length, value}
  function automatic logic [20:0] sync_frame(input logic [1:0] sel,
      input logic six, input logic [7:0] lo, input logic [7:0] hi);
    case (sel)
      2'h1: return {5'h10, hi, lo};                      // [R5]
      2'h0, 2'h3: return six ? {5'h06, 10'h000, lo[5:0]} // [R3] [R6]
                             : {5'h08, 8'h00, lo};       // [R4]
      default: return {5'h08, 8'h00, lo};
    endcase
  endfunction

  // One CRC step on a transmitted bit
  function automatic logic [15:0] crc_step(input logic [15:0] c,
      input logic b, input logic use16);
    logic [15:0] poly;
    poly = use16 ? `BSST_POLY_CRC16 : `BSST_POLY_CCITT;
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? poly : 16'h0000);
  endfunction

  // Bit reversal so the CRC leaves MSB first from an LSB-first shifter
  function automatic logic [15:0] rev16(input logic [15:0] c);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) begin
      r[i] = c[15 - i];
    end
    return r;
  endfunction

  // ========================================================================
  // Declarations
  logic [7:0]  mode, rx_ctrl, tx_ctrl, sync_lo, sync_hi, misc, ext_ctrl;
  logic        chan_rst, srst, eom;
  logic [7:0]  fifo_mem [4];
  logic [1:0]  wr_ptr, rd_ptr;
  logic [2:0]  fifo_cnt;
  logic        txc_m, txc_s, txc_d, cts_m, cts_s, fall;
  logic [15:0] sh, crc;
  logic [4:0]  cnt;
  bsst_kind_t  kind, next_kind;
  logic        crc_on, next_crc_on;
  logic        next_bit, pop, eom_set;
  logic [15:0] next_sh;
  logic [4:0]  next_cnt;
  logic [20:0] ld;
  logic        sync_mode, tx_run, tbe, all_sent;
  logic [1:0]  clk_mode;
  logic        req, wr, wr_data, push;
  logic [5:0]  idx;

  // ========================================================================
  // Bus decode
  assign req     = wb_i.cyc & wb_i.stb & ~wb_ack_o;
  assign idx     = wb_i.adr[7:2];
  assign wr      = req & wb_i.we & wb_i.sel[0];
  assign wr_data = wr & (idx == `BSST_OFS_TXDATA);
  assign push    = wr_data & (fifo_cnt != `BSST_FIFO_DEPTH);
  assign srst    = rst_i | chan_rst;

  // Acknowledge each request one cycle after it appears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read data; control registers are write only and read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_i.we && idx == `BSST_OFS_STATUS) begin
      wb_dat_o <= {21'h000000, fifo_cnt, clk_mode, tx_run, sync_mode,
                   ~cts_s, all_sent, eom, tbe};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // Channel or hardware reset command clears the whole channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_rst <= 1'b0;
    end else begin
      chan_rst <= wr & (idx == `BSST_OFS_MRESET) & (|wb_i.dat[7:6]); // [R1]
    end
  end

  // ========================================================================
  // Control registers
  always_ff @(posedge clk_i) begin
    if (srst) begin
      mode     <= `BSST_REG_RST;
      rx_ctrl  <= `BSST_REG_RST;
      tx_ctrl  <= `BSST_REG_RST;
      sync_lo  <= `BSST_REG_RST;
      sync_hi  <= `BSST_REG_RST;
      misc     <= `BSST_REG_RST;
      ext_ctrl <= `BSST_REG_RST;
    end else if (wr) begin
      case (idx)
        `BSST_OFS_MODE:    mode     <= wb_i.dat[7:0];
        `BSST_OFS_RXCTL:   rx_ctrl  <= wb_i.dat[7:0];
        `BSST_OFS_TXCTL:   tx_ctrl  <= wb_i.dat[7:0];
        `BSST_OFS_SYNCLO:  sync_lo  <= wb_i.dat[7:0];
        `BSST_OFS_SYNCHI:  sync_hi  <= wb_i.dat[7:0];
        `BSST_OFS_MISC:    misc     <= wb_i.dat[7:0];
        `BSST_OFS_EXTFIFO: ext_ctrl <= wb_i.dat[7:0];
        default: ;
      endcase
    end
  end

  // Modem pins; the receiver itself sits outside this block
  always_ff @(posedge clk_i) begin
    if (srst) begin
      rts_n_o <= 1'b1;
      rx_en_o <= 1'b0;
    end else begin
      rts_n_o <= ~tx_ctrl[1]; // [R20]
      rx_en_o <= rx_ctrl[0];  // [R2]
    end
  end

  // ========================================================================
  // Mode decode; clock mode only honoured in external sync, where a
  // nonzero value is a special mode this transmitter does not serve
  assign sync_mode = (mode[3:2] == 2'h0);                       // [R7]
  assign clk_mode  = (mode[5:4] == 2'h3) ? mode[7:6] : 2'h0;    // [R8]
  assign tx_run    = tx_ctrl[3] & sync_mode & (clk_mode == 2'h0) // [R2]
                   & ~(rx_ctrl[5] & cts_s);                     // [R21]
  assign tbe       = ext_ctrl[5] ? (fifo_cnt != `BSST_FIFO_DEPTH)
                                 : (fifo_cnt == 3'h0);          // [R17]
  assign all_sent  = (fifo_cnt == 3'h0) & (kind != BSST_DATA)
                   & (kind != BSST_CRC);

  // ========================================================================
  // Line synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txc_m <= 1'b1;
      txc_s <= 1'b1;
      txc_d <= 1'b1;
      cts_m <= 1'b1;
      cts_s <= 1'b1;
    end else begin
      txc_m <= txc_i;
      txc_s <= txc_m;
      txc_d <= txc_s;
      cts_m <= cts_n_i;
      cts_s <= cts_m;
    end
  end

  // Data changes on the falling edge so the partner samples on the rising
  assign fall = txc_d & ~txc_s;

  // ========================================================================
  // Transmit queue; a write to a full queue is dropped
  always_ff @(posedge clk_i) begin
    if (push) begin
      fifo_mem[wr_ptr] <= wb_i.dat[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst) begin
      wr_ptr   <= 2'h0;
      rd_ptr   <= 2'h0;
      fifo_cnt <= 3'h0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (fall && pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      fifo_cnt <= fifo_cnt + {2'h0, push} - {2'h0, fall & pop};
    end
  end

  // ========================================================================
  // Next character choice; cnt holds bits still to send after the one
  // on the line, so a new character follows with no gap
  always_comb begin
    ld          = sync_frame(mode[5:4], misc[0], sync_lo, sync_hi);
    next_kind   = kind;
    next_crc_on = crc_on;
    pop         = 1'b0;
    eom_set     = 1'b0;
    if (cnt != 5'h00) begin
      ld        = {5'h00, 16'h0000};
    end else if (!tx_run) begin
      next_kind   = BSST_IDLE;
      next_crc_on = 1'b0;
      ld          = {5'h01, 16'hffff};
    end else if (fifo_cnt != 3'h0) begin
      ld = data_frame(fifo_mem[rd_ptr], tx_ctrl[6:5],       // [R9]
                      mode[0], mode[1]);                    // [R11]
      pop         = 1'b1;
      next_kind   = BSST_DATA;
      next_crc_on = tx_ctrl[0];                             // [R16]
    end else if (kind == BSST_DATA && !eom) begin
      ld          = {5'h10, rev16(crc)};                    // [R19]
      eom_set     = 1'b1;
      next_kind   = BSST_CRC;
      next_crc_on = 1'b0;
    end else begin
      next_kind   = BSST_SYNC;                              // [R22]
      next_crc_on = 1'b0;                                   // [R15]
    end
    if (cnt != 5'h00) begin
      next_bit = sh[0];
      next_sh  = {1'b1, sh[15:1]};
      next_cnt = cnt - 5'h01;
    end else begin
      next_bit = ld[0];                                     // [R18]
      next_sh  = {1'b1, ld[15:1]};
      next_cnt = ld[20:16] - 5'h01;
    end
  end

  // Shifter and line output, advanced on each transmit clock fall
  always_ff @(posedge clk_i) begin
    if (srst) begin
      sh     <= 16'hffff;
      cnt    <= 5'h00;
      kind   <= BSST_IDLE;
      crc_on <= 1'b0;
      txd_o  <= 1'b1;
    end else if (fall) begin
      sh     <= next_sh;
      cnt    <= next_cnt;
      kind   <= next_kind;
      crc_on <= next_crc_on;
      txd_o  <= next_bit;
    end
  end

  // CRC generator; preset by command only, never by itself
  always_ff @(posedge clk_i) begin
    if (srst) begin
      crc <= 16'h0000;
    end else if (wr && idx == `BSST_OFS_CMD
                 && wb_i.dat[7:6] == `BSST_CMD_TXCRC) begin  // [R14]
      crc <= misc[7] ? 16'hffff : 16'h0000;                // [R13]
    end else if (fall && next_kind == BSST_DATA && next_crc_on) begin
      crc <= crc_step(crc, next_bit, tx_ctrl[2]);         // [R12] [R15]
    end
  end

  // End-of-message latch; the hardware set wins over a clear
  always_ff @(posedge clk_i) begin
    if (srst) begin
      eom <= 1'b1;
    end else if (fall && eom_set) begin
      eom <= 1'b1;                                          // [R19]
    end else if ((wr && idx == `BSST_OFS_CMD
                  && wb_i.dat[7:6] == `BSST_CMD_EOM)
                 || (push && ext_ctrl[1])) begin
      eom <= 1'b0;
    end
  end

  // ========================================================================
  // Checks
  rts_pin_a: assert property (@(posedge clk_i) disable iff (srst) // [R20]
    ##1 rts_n_o == !$past(tx_ctrl[1]))
    else $error("rts pin does not follow transmit control");

  cts_gate_a: assert property (@(posedge clk_i) disable iff (srst) // [R21]
    (rx_ctrl[5] && cts_s) |-> !tx_run)
    else $error("transmitter runs while clear-to-send is high");

  tx_enable_a: assert property (@(posedge clk_i) disable iff (srst) // [R2]
    (fall && cnt == 5'h00 && !tx_ctrl[3]) |=> kind == BSST_IDLE && txd_o)
    else $error("transmitter left idle while disabled");

  sync_six_a: assert property (@(posedge clk_i) disable iff (srst) // [R3]
    (fall && next_kind == BSST_SYNC && cnt == 5'h00 && mode[5:4] == 2'h0
     && misc[0]) |=> cnt == 5'h05 && txd_o == $past(sync_lo[0]))
    else $error("six-bit sync length wrong");

  sync_pair_a: assert property (@(posedge clk_i) disable iff (srst) // [R5]
    (fall && next_kind == BSST_SYNC && cnt == 5'h00 && mode[5:4] == 2'h1
     && !misc[0]) |=> cnt == 5'h0f)
    else $error("sixteen-bit sync length wrong");

  crc_hold_a: assert property (@(posedge clk_i) disable iff (srst) // [R15]
    (fall && next_kind != BSST_DATA && !wr) |=> $stable(crc))
    else $error("crc moved outside data characters");

  eom_crc_a: assert property (@(posedge clk_i) disable iff (srst) // [R19]
    (fall && eom_set) |=> eom && kind == BSST_CRC && cnt == 5'h0f)
    else $error("underrun did not start crc and set latch");

  crc_preset_a: assert property (@(posedge clk_i) disable iff (srst) // [R13]
    (wr && idx == `BSST_OFS_CMD && wb_i.dat[7:6] == `BSST_CMD_TXCRC)
    |=> crc == ($past(misc[7]) ? 16'hffff : 16'h0000))
    else $error("crc preset value wrong");

  tbe_flag_a: assert property (@(posedge clk_i) disable iff (srst) // [R17]
    (!ext_ctrl[5] && fifo_cnt != 3'h0) |-> !tbe)
    else $error("buffer empty flag with data queued");

endmodule

// file: bsst_line_model.sv
// Line partner: makes the free-running 1x transmit clock, records txd.
// Assumes the transmitter changes txd shortly after each falling edge.
module bsst_line_model (
  // Serial line
  input  wire logic        txd_i,
  output      logic        txc_o,
  output      logic [63:0] hist_o = '1
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==================================================================
  // Clock: runs free, as sync idle never stops; phase offset on purpose
  initial begin
    txc_o  = 1'b0;
    #37;
    forever #100 txc_o = ~txc_o;
  end

  // Sample a full period after launch; newest bit enters at the top
  always @(negedge txc_o) begin
    hist_o <= {txd_i, hist_o[63:1]};
  end
endmodule

// file: tb_bsst_tx.sv
// Testbench of the byte-synchronous transmitter: Wishbone master tasks,
// line partner model, one task per scenario.
// Assumes the package and the line model are compiled first.
module tb_bsst_tx;
  import bsst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ==================================================================
  // Register byte addresses
  localparam logic [7:0] a_cmd = 8'h00, a_mrs = 8'h04, a_mode = 8'h08;
  localparam logic [7:0] a_rx = 8'h0c, a_tx = 8'h10, a_slo = 8'h14;
  localparam logic [7:0] a_shi = 8'h18, a_misc = 8'h1c, a_dat = 8'h24;
  localparam logic [7:0] a_st = 8'h28;

  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  bsst_wb_req_t wb    = '0;
  logic         cts_n = 1'b0;
  logic         wb_ack_o;
  logic [31:0]  wb_dat_o;
  logic         txc;
  logic         txd_o;
  logic         rts_n_o;
  logic         rx_en_o;
  logic [63:0]  hist;
  logic [31:0]  q;
  int           fail_count = 0;
  int           num_checks = 0;

  always #12.5 clk_i = ~clk_i;

  bsst_tx dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .txc_i(txc),
    .cts_n_i(cts_n), .txd_o(txd_o), .rts_n_o(rts_n_o),
    .rx_en_o(rx_en_o));
  bsst_line_model line_u (.txd_i(txd_o), .txc_o(txc), .hist_o(hist));

  // ==================================================================
  // Shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb_x(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb <= '{1'b1, 1'b1, we, a, 4'hf, d};
    // Look just after each edge: what stands now is sampled at the next
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) check(1'b0, 1'b1);
    r = wb_dat_o;
    @(posedge clk_i);
    wb.cyc <= 1'b0;
    wb.stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb_x(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a);
    wb_x(1'b0, a, 32'h0, q);
  endtask

  // Look for k line bits, earliest at the LSB, within a bounded wait
  task automatic pat(input logic [63:0] exp, input int k);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 100 && !hit; i++) begin
      @(negedge txc);
      #1;
      if ((hist >> (64 - k)) === exp) hit = 1'b1;
    end
    check(hit, 1'b1);
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==================================================================
  // Scenarios
  task automatic t_reset;
    rd(a_st);
    check(q[1:0], 2'b11);
    check(q[10:8], 3'h0);
    check({txd_o, rts_n_o, rx_en_o}, 3'b110);
    rd(8'h3c);
    check(q, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_init;
    wr(a_mrs, 32'hc0);
    repeat (2) @(posedge clk_i);
    wr(a_mode, 32'h00);
    wr(a_rx, 32'h01);
    wr(a_slo, 32'h16);
    wr(a_tx, 32'h62);
    repeat (2) @(posedge clk_i);
    check({rx_en_o, rts_n_o}, 2'b10);
    pat(64'hffff, 16);
    wr(a_tx, 32'h6a);
    pat(64'h1616, 16);
    $display("test init done");
  endtask

  task automatic t_sync;
    wr(a_slo, 32'hd6);
    wr(a_misc, 32'h01);
    pat({3{6'h16}}, 18);
    wr(a_misc, 32'h00);
    wr(a_shi, 32'h32);
    wr(a_mode, 32'h10);
    pat({2{16'h32d6}}, 32);
    wr(a_mode, 32'h30);
    wr(a_misc, 32'h01);
    pat({3{6'h16}}, 18);
    wr(a_misc, 32'h00);
    pat({2{8'hd6}}, 16);
    wr(a_slo, 32'h16);
    $display("test sync done");
  endtask

  task automatic t_mode;
    wr(a_mode, 32'h04);
    pat(64'hffff, 16);
    wr(a_mode, 32'hf0);
    pat(64'hffff, 16);
    rd(a_st);
    check(q[7:6], 2'b11);
    wr(a_mode, 32'hc0);
    pat(64'h1616, 16);
    rd(a_st);
    check(q[7:6], 2'b00);
    wr(a_mode, 32'h00);
    wr(a_rx, 32'h21);
    @(posedge clk_i) cts_n <= 1'b1;
    pat(64'hffff, 16);
    @(posedge clk_i) cts_n <= 1'b0;
    pat(64'h1616, 16);
    wr(a_rx, 32'h01);
    $display("test mode done");
  endtask

  // Data character with a given length and parity setting
  task automatic dcase(input logic [7:0] tx, input logic [7:0] m,
                       input logic [7:0] d, input logic [63:0] e,
                       input int k);
    wr(a_mode, {24'h0, m});
    wr(a_tx, {24'h0, tx});
    wr(a_dat, {24'h0, d});
    pat(e, k);
  endtask

  task automatic t_data;
    dcase(8'h6a, 8'h00, 8'h41, {8'h16, 8'h41, 8'h16}, 24);
    dcase(8'h4a, 8'h00, 8'hc1, {8'h16, 6'h01, 8'h16}, 22);
    dcase(8'h2a, 8'h00, 8'h81, {8'h16, 7'h01, 8'h16}, 23);
    dcase(8'h0a, 8'h00, 8'he1, {8'h16, 2'h1, 8'h16}, 18);
    dcase(8'h6a, 8'h03, 8'h41, {1'b0, 8'h41}, 9);
    dcase(8'h6a, 8'h01, 8'h41, {1'b1, 8'h41}, 9);
    wr(a_mode, 32'h00);
    $display("test data done");
  endtask

  // Character kept out of a ones preset, then zeros preset with CRC on
  task automatic t_crc;
    wr(a_misc, 32'h80);
    wr(a_cmd, 32'h80);
    wr(a_dat, 32'h00);
    wr(a_cmd, 32'hc0);
    pat({8'h16, 16'hffff, 8'h00}, 32);
    rd(a_st);
    check(q[1], 1'b1);
    wr(a_misc, 32'h00);
    wr(a_cmd, 32'h80);
    wr(a_tx, 32'h6b);
    wr(a_dat, 32'h01);
    wr(a_cmd, 32'hc0);
    pat({8'h16, 16'h1189, 8'h01}, 32);
    $display("test crc done");
  endtask

  // ==================================================================
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_init();
    t_sync();
    t_mode();
    t_data();
    t_crc();
    stop_test();
  end

  // Every wait is bounded; this catches a hang anywhere else
  initial begin
    #1ms;
    fail_count++;
    stop_test();
  end
endmodule
